/* anp_consts.svh */
// register offsets, field positions, reset values and limits for the alarm/notify/pressure bank
`ifndef ANP_CONSTS_SVH
`define ANP_CONSTS_SVH
`define ANP_OFS_NOTIFY_CFG 8'h08
`define ANP_OFS_ALARM_TH_MSB 8'h09
`define ANP_OFS_ALARM_TH_LSB 8'h0a
`define ANP_OFS_PRES_MSB 8'h0b
`define ANP_OFS_PRES_LSB 8'h0c
`define ANP_OFS_STATUS 8'h0d
`define ANP_RST_NOTIFY_CFG 8'h00
`define ANP_RST_ALARM_TH 8'h00
`define ANP_RST_PRES_MSB 8'h03
`define ANP_RST_PRES_LSB 8'hf7
`define ANP_BIT_POLARITY 4
`define ANP_FUNC_HI 3
`define ANP_FUNC_LO 1
`define ANP_BIT_DIRECTION 0
`define ANP_PRES_MIN 16'h02ee
`define ANP_PRES_MAX 16'h047e
`define ANP_MODE_CONT 2'h2
`define ANP_STS_RANGE_ERR 0
`define ANP_STS_ALARM 1
`define ANP_STS_COMP_ON 2
`endif

/* anp_host_model.sv */
// host model driving the byte-wide register strobes
`timescale 1ns/100ps
module anp_host_model (
   input wire logic mclk,
   output logic wrEn,
   output logic rdEn,
   output logic [7:0] regAddr,
   output logic [7:0] wrData,
   input wire logic [7:0] rdData
);
   initial
   begin
      wrEn = 1'b0;
      rdEn = 1'b0;
      regAddr = 8'h00;
      wrData = 8'h00;
   end
   // released lines show the inverse so stale values never match by chance
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      regAddr = a;
      wrData = d;
      wrEn = 1'b1;
      @(negedge mclk);
      wrEn = 1'b0;
      wrData = ~d;
      regAddr = ~a;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge mclk);
      regAddr = a;
      rdEn = 1'b1;
      @(negedge mclk);
      rdEn = 1'b0;
      d = rdData;
      regAddr = ~a;
   endtask
   task automatic wrPres(input logic [15:0] v);
      wr(8'h0b, v[15:8]);
      wr(8'h0c, v[7:0]);
   endtask
endmodule

/* anp_pkg.sv */
// types for the alarm/notify/pressure register bank
package anp_pkg;
   typedef enum logic [2:0] {
      ANP_FN_OFF = 3'h0,
      ANP_FN_ALARM = 3'h1,
      ANP_FN_DRDY = 3'h2,
      ANP_FN_BUSY = 3'h3,
      ANP_FN_EARLY = 3'h4
   } anp_func_t;
endpackage

/* anp_regs.sv */
// alarm threshold, notification pin and pressure reference register logic
// Behaviour
// - function select in config bits 3:1; 000 keeps notify pin inactive
// - select 001 drives pin on alarm threshold violation
// - select 010 drives pin on new data ready
// - select 011 drives pin while sensor busy
// - select 100 signals early start, only in continuous mode 10
// - config bit 0 chooses alarm direction
// - direction 0: alarm when concentration falls below threshold
// - direction 1: alarm when concentration rises above threshold
// - threshold is msb byte concatenated with lsb byte
// - threshold is signed 16-bit, one lsb per ppm
// - pressure is unsigned 16-bit msb:lsb, one lsb per hPa
// - lsb pressure write loads both bytes into the shadow
// - msb pressure write leaves the shadow untouched
// - pressure at reset default means compensation disabled
// - out-of-range pressure clamps to limit and register updates
// - out-of-range pressure write sets range error flag
// - alarm flag sticks at end of a violating measurement
// - polarity bit write forces notify pin inactive
`timescale 1ns/100ps
`include "anp_consts.svh"
module anp_regs
   import anp_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic wrEn,
   input wire logic rdEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] wrData,
   output logic [7:0] rdData,
   input wire logic [1:0] operatingModeSel,
   input wire logic measDone,
   input wire logic signed [15:0] co2Ppm,
   input wire logic dataReady,
   input wire logic sensorBusy,
   input wire logic earlyStart,
   input wire logic alarmFlagClr,
   input wire logic notifyLatchClr,
   input wire logic rangeErrClr,
   output logic notifyPin,
   output logic [15:0] pressureShadow,
   output logic pressureCompEn,
   output logic thresholdViolationFlag,
   output logic configRangeErrorFlag
);

   // -------------------------------
   // register storage
   // -------------------------------
   logic [7:0] notifyCfg_r;
   logic [7:0] thMsb_r;
   logic [7:0] thLsb_r;
   logic [7:0] presMsb_r;
   logic [7:0] presLsb_r;
   logic [15:0] shadow_r;
   logic alarmFlag_r;
   logic rangeErr_r;
   logic pinLatch_r;
   logic [15:0] prevConc_r;
   logic prevValid_r;

   // -------------------------------
   // decode
   // -------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   wire wrCfg = wrEn && hit(regAddr, `ANP_OFS_NOTIFY_CFG);
   wire wrThM = wrEn && hit(regAddr, `ANP_OFS_ALARM_TH_MSB);
   wire wrThL = wrEn && hit(regAddr, `ANP_OFS_ALARM_TH_LSB);
   wire wrPrM = wrEn && hit(regAddr, `ANP_OFS_PRES_MSB);
   wire wrPrL = wrEn && hit(regAddr, `ANP_OFS_PRES_LSB);

   wire [2:0] funcSel = notifyCfg_r[`ANP_FUNC_HI:`ANP_FUNC_LO];
   wire direction = notifyCfg_r[`ANP_BIT_DIRECTION];
   wire activeHigh = notifyCfg_r[`ANP_BIT_POLARITY];
   // a polarity write counts as changed when the written bit differs or not
   wire polWrite = wrCfg;

   // -------------------------------
   // threshold comparison
   // -------------------------------
   wire signed [15:0] threshold = {thMsb_r, thLsb_r};
   wire below = co2Ppm < threshold;
   wire prevAbove = $signed(prevConc_r) >= threshold;
   wire prevBelow = $signed(prevConc_r) <= threshold;
   wire crossDown = prevValid_r && prevAbove && below;
   wire crossUp = prevValid_r && prevBelow && (co2Ppm > threshold);
   wire violation = measDone && (direction ? crossUp : crossDown);

   // -------------------------------
   // pressure clamp
   // -------------------------------
   wire [15:0] presWr = {presMsb_r, wrData};
   wire presLow = presWr < `ANP_PRES_MIN;
   wire presHigh = presWr > `ANP_PRES_MAX;
   wire [15:0] presClamped = presLow ? `ANP_PRES_MIN :
                             (presHigh ? `ANP_PRES_MAX : presWr);
   wire presOut = presLow || presHigh;

   // -------------------------------
   // notify function selection
   // -------------------------------
   logic fnActive;
   always_comb
   begin
      case (funcSel)
         ANP_FN_OFF: fnActive = 1'b0;
         ANP_FN_ALARM: fnActive = pinLatch_r;
         ANP_FN_DRDY: fnActive = pinLatch_r;
         ANP_FN_BUSY: fnActive = sensorBusy;
         ANP_FN_EARLY: fnActive = earlyStart && (operatingModeSel == `ANP_MODE_CONT);
         default: fnActive = 1'b0;
      endcase
   end

   wire latchSet = measDone && ((funcSel == ANP_FN_ALARM && violation) ||
                                (funcSel == ANP_FN_DRDY && dataReady));

   // -------------------------------
   // sequential
   // -------------------------------
   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         notifyCfg_r <= `ANP_RST_NOTIFY_CFG;
         thMsb_r <= `ANP_RST_ALARM_TH;
         thLsb_r <= `ANP_RST_ALARM_TH;
         presMsb_r <= `ANP_RST_PRES_MSB;
         presLsb_r <= `ANP_RST_PRES_LSB;
         shadow_r <= {`ANP_RST_PRES_MSB, `ANP_RST_PRES_LSB};
         alarmFlag_r <= 1'b0;
         rangeErr_r <= 1'b0;
         pinLatch_r <= 1'b0;
         prevConc_r <= 16'h0000;
         prevValid_r <= 1'b0;
         notifyPin <= 1'b1;
      end
      else
      begin
         if (wrCfg)
            notifyCfg_r <= wrData;
         if (wrThM)
            thMsb_r <= wrData;
         if (wrThL)
            thLsb_r <= wrData;
         if (wrPrM)
            presMsb_r <= wrData;
         if (wrPrL)
         begin
            presMsb_r <= presClamped[15:8];
            presLsb_r <= presClamped[7:0];
            shadow_r <= presClamped;
         end
         // set wins over clear for every sticky flag
         if (violation)
            alarmFlag_r <= 1'b1;
         else if (alarmFlagClr)
            alarmFlag_r <= 1'b0;
         if (wrPrL && presOut)
            rangeErr_r <= 1'b1;
         else if (rangeErrClr)
            rangeErr_r <= 1'b0;
         if (latchSet)
            pinLatch_r <= 1'b1;
         else if (notifyLatchClr || polWrite)
            pinLatch_r <= 1'b0;
         if (measDone)
         begin
            prevConc_r <= co2Ppm;
            prevValid_r <= 1'b1;
         end
         // polarity change takes effect after write, pin held inactive that cycle
         if (polWrite)
            notifyPin <= ~wrData[`ANP_BIT_POLARITY];
         else
            notifyPin <= activeHigh ? fnActive : ~fnActive;
      end
   end

   // -------------------------------
   // outputs and read mux
   // -------------------------------
   assign pressureShadow = shadow_r;
   // default value means firmware skips compensation
   assign pressureCompEn = shadow_r != {`ANP_RST_PRES_MSB, `ANP_RST_PRES_LSB};
   assign thresholdViolationFlag = alarmFlag_r;
   assign configRangeErrorFlag = rangeErr_r;

   wire [7:0] stsByte = {5'h00, pressureCompEn, alarmFlag_r, rangeErr_r};
   wire [7:0] rdMux =
      hit(regAddr, `ANP_OFS_NOTIFY_CFG) ? {3'h0, notifyCfg_r[4:0]} :
      hit(regAddr, `ANP_OFS_ALARM_TH_MSB) ? thMsb_r :
      hit(regAddr, `ANP_OFS_ALARM_TH_LSB) ? thLsb_r :
      hit(regAddr, `ANP_OFS_PRES_MSB) ? presMsb_r :
      hit(regAddr, `ANP_OFS_PRES_LSB) ? presLsb_r :
      hit(regAddr, `ANP_OFS_STATUS) ? stsByte : 8'h00;

   always_ff @(posedge mclk)
   begin
      if (srst)
         rdData <= 8'h00;
      else if (rdEn)
         rdData <= rdMux;
   end

   // -------------------------------
   // assertions
   // -------------------------------
   a_off_inactive: assert property (@(posedge mclk) disable iff (srst)
      (!wrCfg && funcSel == 3'h0) |=> (notifyPin == ~activeHigh))
      else $error("notify pin active with function off");
   a_rsvd_inactive: assert property (@(posedge mclk) disable iff (srst)
      (!wrCfg && funcSel > 3'h4) |=> (notifyPin == ~activeHigh))
      else $error("notify pin active with reserved function");
   a_busy_follow: assert property (@(posedge mclk) disable iff (srst)
      (!wrCfg && funcSel == 3'h3) |=> (notifyPin == (activeHigh ~^ $past(sensorBusy))))
      else $error("busy not reflected on notify pin");
   a_early_mode: assert property (@(posedge mclk) disable iff (srst)
      (!wrCfg && funcSel == 3'h4 && operatingModeSel != 2'h2) |=> (notifyPin == ~activeHigh))
      else $error("early start outside continuous mode");
   a_shadow_hold: assert property (@(posedge mclk) disable iff (srst)
      (!wrPrL) |=> $stable(shadow_r))
      else $error("shadow changed without lsb write");
   a_shadow_load: assert property (@(posedge mclk) disable iff (srst)
      wrPrL |=> (shadow_r == {presMsb_r, presLsb_r}))
      else $error("shadow not loaded on lsb write");
   a_clamp_range: assert property (@(posedge mclk) disable iff (srst)
      wrPrL |=> (shadow_r >= `ANP_PRES_MIN && shadow_r <= `ANP_PRES_MAX))
      else $error("pressure outside clamp range");
   a_range_err: assert property (@(posedge mclk) disable iff (srst)
      (wrPrL && presOut) |=> rangeErr_r)
      else $error("range error flag not set");
   a_alarm_sticky: assert property (@(posedge mclk) disable iff (srst)
      violation |=> alarmFlag_r)
      else $error("alarm flag not set on violation");
   a_pol_inactive: assert property (@(posedge mclk) disable iff (srst)
      wrCfg |=> (notifyPin == ~$past(wrData[4])))
      else $error("polarity write did not force inactive");

   // -------------------------------
   // register and flag assertions
   // -------------------------------
   a_cfg_write: assert property (@(posedge mclk) disable iff (srst)
      wrCfg |=> (notifyCfg_r == $past(wrData)))
      else $error("config write not stored");

   a_cfg_hold: assert property (@(posedge mclk) disable iff (srst)
      (!wrCfg) |=> $stable(notifyCfg_r))
      else $error("config changed without write");

   a_thm_write: assert property (@(posedge mclk) disable iff (srst)
      wrThM |=> (thMsb_r == $past(wrData)))
      else $error("threshold msb not stored");

   a_thl_write: assert property (@(posedge mclk) disable iff (srst)
      wrThL |=> (thLsb_r == $past(wrData)))
      else $error("threshold lsb not stored");

   a_th_hold: assert property (@(posedge mclk) disable iff (srst)
      (!wrThM && !wrThL) |=> $stable(threshold))
      else $error("threshold changed without write");

   a_pres_msb: assert property (@(posedge mclk) disable iff (srst)
      wrPrM |=> (presMsb_r == $past(wrData)))
      else $error("pressure msb not stored");

   a_msb_shadow: assert property (@(posedge mclk) disable iff (srst)
      wrPrM |=> $stable(shadow_r))
      else $error("msb write moved the shadow");

   a_pres_pass: assert property (@(posedge mclk) disable iff (srst)
      (wrPrL && !presOut) |=> (shadow_r == $past({presMsb_r, wrData})))
      else $error("in-range pressure not loaded as written");

   a_clamp_low: assert property (@(posedge mclk) disable iff (srst)
      (wrPrL && presLow) |=> (shadow_r == `ANP_PRES_MIN))
      else $error("low pressure not clamped");

   a_clamp_high: assert property (@(posedge mclk) disable iff (srst)
      (wrPrL && presHigh) |=> (shadow_r == `ANP_PRES_MAX))
      else $error("high pressure not clamped");

   a_reg_mirror: assert property (@(posedge mclk) disable iff (srst)
      wrPrL |=> ({presMsb_r, presLsb_r} == shadow_r))
      else $error("register not updated to clamped value");

   a_range_keep: assert property (@(posedge mclk) disable iff (srst)
      (rangeErr_r && !rangeErrClr) |=> rangeErr_r)
      else $error("range error dropped without clear");

   a_range_clear: assert property (@(posedge mclk) disable iff (srst)
      (rangeErrClr && !(wrPrL && presOut)) |=> !rangeErr_r)
      else $error("range error not cleared");

   a_range_quiet: assert property (@(posedge mclk) disable iff (srst)
      (!rangeErr_r && !wrPrL) |=> !rangeErr_r)
      else $error("range error set without lsb write");

   a_alarm_keep: assert property (@(posedge mclk) disable iff (srst)
      (alarmFlag_r && !alarmFlagClr) |=> alarmFlag_r)
      else $error("alarm flag dropped without clear");

   a_alarm_clear: assert property (@(posedge mclk) disable iff (srst)
      (alarmFlagClr && !violation) |=> !alarmFlag_r)
      else $error("alarm flag not cleared");

   a_alarm_meas: assert property (@(posedge mclk) disable iff (srst)
      (!measDone && !alarmFlag_r) |=> !alarmFlag_r)
      else $error("alarm flag set outside measurement end");

   // full compare spelled out so a broken crossing term still trips
   a_cross_down: assert property (@(posedge mclk) disable iff (srst)
      (measDone && !direction && prevValid_r && $signed(prevConc_r) >= threshold &&
       co2Ppm < threshold) |=> alarmFlag_r)
      else $error("downward crossing missed");

   a_cross_up: assert property (@(posedge mclk) disable iff (srst)
      (measDone && direction && prevValid_r && $signed(prevConc_r) <= threshold &&
       co2Ppm > threshold) |=> alarmFlag_r)
      else $error("upward crossing missed");

   a_alarm_latch: assert property (@(posedge mclk) disable iff (srst)
      (violation && funcSel == ANP_FN_ALARM) |=> pinLatch_r)
      else $error("alarm did not latch notify");

   a_ready_latch: assert property (@(posedge mclk) disable iff (srst)
      (measDone && funcSel == ANP_FN_DRDY && dataReady) |=> pinLatch_r)
      else $error("data ready did not latch notify");

   a_latch_drive: assert property (@(posedge mclk) disable iff (srst)
      (!wrCfg && (funcSel == ANP_FN_ALARM || funcSel == ANP_FN_DRDY)) |=>
      (notifyPin == (activeHigh ~^ $past(pinLatch_r))))
      else $error("latched state not on notify pin");

   a_early_follow: assert property (@(posedge mclk) disable iff (srst)
      (!wrCfg && funcSel == ANP_FN_EARLY && operatingModeSel == `ANP_MODE_CONT) |=>
      (notifyPin == (activeHigh ~^ $past(earlyStart))))
      else $error("early start not on notify pin");

   a_latch_clear: assert property (@(posedge mclk) disable iff (srst)
      (wrCfg && !latchSet) |=> !pinLatch_r)
      else $error("config write left notify latched");

   a_comp_off: assert property (@(posedge mclk) disable iff (srst)
      (shadow_r == {`ANP_RST_PRES_MSB, `ANP_RST_PRES_LSB}) |-> !pressureCompEn)
      else $error("compensation on at default pressure");

   a_rd_hold: assert property (@(posedge mclk) disable iff (srst)
      (!rdEn) |=> $stable(rdData))
      else $error("read data moved without read");
endmodule

/* tb_anp_regs.sv */
// self-checking bench for the alarm/notify/pressure register bank
`timescale 1ns/100ps
`include "anp_consts.svh"
module tb_anp_regs;
   logic mclk, srst, wrEn, rdEn, measDone, dataReady, sensorBusy, earlyStart;
   logic alarmFlagClr, notifyLatchClr, rangeErrClr, notifyPin, pressureCompEn;
   logic thresholdViolationFlag, configRangeErrorFlag;
   logic [7:0] regAddr, wrData, rdData, d;
   logic [1:0] operatingModeSel;
   logic signed [15:0] co2Ppm;
   logic [15:0] pressureShadow;
   int badCount = 0;
   int compares = 0;
   anp_host_model hostU (.mclk(mclk), .wrEn(wrEn), .rdEn(rdEn), .regAddr(regAddr),
      .wrData(wrData), .rdData(rdData));
   anp_regs dut_u (.mclk(mclk), .srst(srst), .wrEn(wrEn), .rdEn(rdEn), .regAddr(regAddr),
      .wrData(wrData), .rdData(rdData), .operatingModeSel(operatingModeSel),
      .measDone(measDone), .co2Ppm(co2Ppm), .dataReady(dataReady), .sensorBusy(sensorBusy),
      .earlyStart(earlyStart), .alarmFlagClr(alarmFlagClr), .notifyLatchClr(notifyLatchClr),
      .rangeErrClr(rangeErrClr), .notifyPin(notifyPin), .pressureShadow(pressureShadow),
      .pressureCompEn(pressureCompEn), .thresholdViolationFlag(thresholdViolationFlag),
      .configRangeErrorFlag(configRangeErrorFlag));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         badCount++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic meas(input logic signed [15:0] p, input logic rdy);
      @(negedge mclk);
      co2Ppm = p;
      dataReady = rdy;
      measDone = 1'b1;
      @(negedge mclk);
      measDone = 1'b0;
      repeat (2) @(negedge mclk);
   endtask
   task automatic clrAll;
      @(negedge mclk);
      {alarmFlagClr, notifyLatchClr, rangeErrClr} = 3'h7;
      @(negedge mclk);
      {alarmFlagClr, notifyLatchClr, rangeErrClr} = 3'h0;
      @(negedge mclk);
   endtask
   task print_verdict;
      if (badCount == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic tReset;
      logic [7:0] adr [5] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h3f};
      logic [7:0] exp [5] = '{8'h00, 8'h00, 8'h03, 8'hf7, 8'h00};
      for (int i = 0; i < 5; i++)
      begin
         hostU.rd(adr[i], d);
         chk({8'h00, d}, {8'h00, exp[i]});
      end
      chk(pressureShadow, 16'h03f7);
      chk({15'h0, pressureCompEn}, 16'h0000);
      chk({15'h0, notifyPin}, 16'h0001);
   endtask
   task automatic tPres;
      hostU.wr(8'h0b, 8'h04);
      chk(pressureShadow, 16'h03f7);
      hostU.wr(8'h0c, 8'h00);
      chk(pressureShadow, 16'h0400);
      chk({15'h0, pressureCompEn}, 16'h0001);
      chk({15'h0, configRangeErrorFlag}, 16'h0000);
      hostU.wrPres(16'h0010);
      chk(pressureShadow, `ANP_PRES_MIN);
      chk({15'h0, configRangeErrorFlag}, 16'h0001);
      hostU.rd(8'h0d, d);
      chk({8'h00, d}, {8'h00, 8'h05});
      hostU.rd(8'h0c, d);
      chk({8'h00, d}, {8'h00, 8'hee});
      clrAll();
      chk({15'h0, configRangeErrorFlag}, 16'h0000);
      hostU.wrPres(16'hffff);
      chk(pressureShadow, `ANP_PRES_MAX);
      chk({15'h0, configRangeErrorFlag}, 16'h0001);
   endtask
   task automatic tFunc;
      @(negedge mclk);
      sensorBusy = 1'b1;
      earlyStart = 1'b1;
      operatingModeSel = `ANP_MODE_CONT;
      // busy and early are live, so only those two selects pull the pin active
      for (int f = 0; f < 8; f++)
      begin
         hostU.wr(8'h08, {4'h0, f[2:0], 1'b0});
         repeat (2) @(negedge mclk);
         chk({15'h0, notifyPin}, {15'h0, !(f == 3 || f == 4)});
      end
      hostU.wr(8'h08, 8'h08);
      repeat (2) @(negedge mclk);
      chk({15'h0, notifyPin}, 16'h0000);
      operatingModeSel = 2'h0;
      repeat (2) @(negedge mclk);
      chk({15'h0, notifyPin}, 16'h0001);
      hostU.wr(8'h08, 8'h10);
      chk({15'h0, notifyPin}, 16'h0000);
      sensorBusy = 1'b0;
      earlyStart = 1'b0;
      hostU.wr(8'h08, 8'h04);
      meas(16'sd100, 1'b1);
      chk({15'h0, notifyPin}, 16'h0000);
      clrAll();
      chk({15'h0, notifyPin}, 16'h0001);
   endtask
   task automatic tAlarm;
      hostU.wr(8'h09, 8'h01);
      hostU.wr(8'h0a, 8'h90);
      hostU.wr(8'h08, 8'h03);
      meas(16'sd300, 1'b0);
      chk({15'h0, thresholdViolationFlag}, 16'h0000);
      meas(16'sd500, 1'b0);
      chk({15'h0, thresholdViolationFlag}, 16'h0001);
      chk({15'h0, notifyPin}, 16'h0000);
      clrAll();
      // negative threshold: an unsigned compare would miss this crossing
      hostU.wr(8'h09, 8'hff);
      hostU.wr(8'h0a, 8'hf6);
      hostU.wr(8'h08, 8'h02);
      meas(16'sd5, 1'b0);
      chk({15'h0, thresholdViolationFlag}, 16'h0000);
      meas(-16'sd20, 1'b0);
      chk({15'h0, thresholdViolationFlag}, 16'h0001);
   endtask
   // ----------------------------------------
   // run
   // ----------------------------------------
   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   initial
   begin
      #200000;
      badCount++;
      print_verdict();
   end
   initial
   begin
      srst = 1'b1;
      {measDone, dataReady, sensorBusy, earlyStart} = 4'h0;
      {alarmFlagClr, notifyLatchClr, rangeErrClr} = 3'h0;
      operatingModeSel = 2'h0;
      co2Ppm = 16'sd0;
      repeat (5) @(negedge mclk);
      srst = 1'b0;
      tReset();
      tPres();
      tFunc();
      tAlarm();
      print_verdict();
   end
endmodule
